// [rtl/sacg_defines.vh]
// Constants of the stepper axis command guard: register offsets, field positions,
// codes and timing counts.
// Assumes a 10 MHz core clock and a byte-addressed register bus with 8 address bits.
`ifndef SACG_DEFINES_VH
`define SACG_DEFINES_VH

// ==========================================================================
// Timing
// ==========================================================================
`define SACG_CLK_MHZ        10
`define SACG_ADJ_WR_US      760
`define SACG_ADJ_RD_US      460
`define SACG_ADJ_WR_CYCLES  (`SACG_ADJ_WR_US * `SACG_CLK_MHZ)
`define SACG_ADJ_RD_CYCLES  (`SACG_ADJ_RD_US * `SACG_CLK_MHZ)

// ==========================================================================
// Register offsets (byte addresses)
// ==========================================================================
`define SACG_OFF_CTRL       8'h00
`define SACG_OFF_CMD        8'h04
`define SACG_OFF_ADJ_NEW    8'h08
`define SACG_OFF_ADJ_READ   8'h0C
`define SACG_OFF_ADJ_SAVED  8'h10
`define SACG_OFF_STATUS     8'h14
`define SACG_OFF_EXCHANGE_REPORT_WORD   8'h18
`define SACG_OFF_CHANNEL_FAULT_WORD     8'h1C
`define SACG_OFF_REFUSE     8'h20
`define SACG_OFF_IRQ_STS    8'h24
`define SACG_OFF_IRQ_MASK   8'h28

// ==========================================================================
// Control register fields
// ==========================================================================
`define SACG_CTRL_EN        0
`define SACG_CTRL_ACK       1
`define SACG_CTRL_MODE_LO   2
`define SACG_CTRL_RUN       4
`define SACG_CTRL_EVT_AUTH  5
`define SACG_CTRL_EVT_UNM   6
`define SACG_CTRL_RESET     7'h00

// ==========================================================================
// Command register fields (write-only strobes)
// ==========================================================================
`define SACG_CMD_MOVE       0
`define SACG_CMD_DIR        1
`define SACG_CMD_EVSRC      2
`define SACG_CMD_STOP       3
`define SACG_CMD_FREF       4
`define SACG_CMD_AWR        5
`define SACG_CMD_ARD        6
`define SACG_CMD_ASAVE      7
`define SACG_CMD_STSRD      8
`define SACG_CMD_COLD       9
`define SACG_CMD_DBG        10

// ==========================================================================
// Modes and refusal codes
// ==========================================================================
`define SACG_MODE_IDLE      2'h0
`define SACG_MODE_MANUAL    2'h1
`define SACG_MODE_AUTO      2'h2
`define SACG_MODE_DIRECT    2'h3
`define SACG_REF_NONE       8'h00
`define SACG_REF_STOPPED    8'h01
`define SACG_REF_DISABLED   8'h02
`define SACG_REF_NOMODE     8'h03
`define SACG_REF_LOCKED     8'h04
`define SACG_REF_FAULT      8'h05
`define SACG_REF_EOR_DIR    8'h06
`define SACG_REF_NOTREF     8'h07
`define SACG_REF_ADJ_BUSY   8'h08
`define SACG_REF_FREF       8'h09

// Interrupt status bits
`define SACG_IRQ_REFUSE     0
`define SACG_IRQ_FAULT      1
`define SACG_IRQ_DONE       2
`define SACG_IRQ_ADJ        3
`endif

// [rtl/sacg_top.v]
// Stepper axis command guard: motion command acceptance, fault recovery,
// adjustment exchanges and status snapshots behind an AXI4-Lite slave.
// Assumes one 10 MHz clock; limit pins arrive asynchronously from the moving part.
`timescale 1ns/1ps
`include "sacg_defines.vh"
`default_nettype none

// Behaviour
// - Adjustment write while an adjustment exchange runs is dropped; old parameters stay.
// - Event raised only when the motion command unmasked its source.
// - Event reaches host only when globally authorised and system-unmasked.
// - Cold start restores saved parameters, losing unsaved adjustments.
// - Exchange report and fault words refresh only on status read request.
// - Debug commands have no effect while the application is stopped.
// - Soft-stop overshoot while monitored stops the axis with a fault.
// - After that overshoot in direct drive, all moves there are refused until recovery.
// - Past an end-of-run limit only moves back toward the limits are accepted.
module sacg_top #(
  parameter [15:0] ADJ_WR_CYCLES = `SACG_ADJ_WR_CYCLES,
  parameter [15:0] ADJ_RD_CYCLES = `SACG_ADJ_RD_CYCLES
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        soft_over_pin,
  input  wire        eor_high_pin,
  input  wire        eor_low_pin,
  output reg         axis_run_q,
  output reg         axis_dir_q,
  output reg         event_out_q,
  output reg         irq_q
);

  function [31:0] be_mask;
    input [3:0] strb;
    begin
      be_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a <= `SACG_OFF_IRQ_MASK);
    end
  endfunction

  // ==========================================================================
  // AXI4-Lite slave
  // ==========================================================================
  reg        aw_hold_q;
  reg        w_hold_q;
  reg [7:0]  waddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  wire       wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire [31:0] wr_val = wdata_q & be_mask(wstrb_q);
  reg [31:0] rd_d;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      waddr_q       <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        aw_hold_q     <= 1'b1;
        waddr_q       <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(waddr_q) ? 2'b00 : 2'b11;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_d;
        s_axi_rresp   <= is_mapped({s_axi_araddr[7:2], 2'b00}) ? 2'b00 : 2'b11;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Limit pin synchronisers: a change counts once stages two and three agree
  // ==========================================================================
  reg [2:0] sync1_q;
  reg [2:0] sync2_q;
  reg [2:0] sync3_q;
  reg [2:0] pins_q;
  wire      soft_f    = pins_q[0];
  wire      eor_hi_f  = pins_q[1];
  wire      eor_lo_f  = pins_q[2];

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 3'b000;
      sync2_q <= 3'b000;
      sync3_q <= 3'b000;
      pins_q  <= 3'b000;
    end else begin
      sync1_q <= {eor_low_pin, eor_high_pin, soft_over_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pins_q  <= (sync2_q & sync3_q) | (pins_q & (sync2_q ^ sync3_q));
    end
  end

  // ==========================================================================
  // Control state
  // ==========================================================================
  reg [6:0]  ctrl_q;
  reg [31:0] adj_new_q;
  reg [31:0] adj_work_q;
  reg [31:0] adj_pend_q;
  reg [31:0] adj_read_q;
  reg [31:0] adj_saved_q;
  reg [15:0] busy_cnt_q;
  reg        pend_wr_q;
  reg        ref_q;
  reg        fault_q;
  reg        lock_q;
  reg        ev_src_q;
  reg        en_prev_q;
  reg        ack_prev_q;
  reg [15:0] exchange_report_word_q;
  reg [15:0] channel_fault_word_q;
  reg [7:0]  refuse_q;
  reg [3:0]  irq_sts_q;
  reg [3:0]  irq_mask_q;

  wire [1:0] mode     = ctrl_q[`SACG_CTRL_MODE_LO+1:`SACG_CTRL_MODE_LO];
  wire       enable   = ctrl_q[`SACG_CTRL_EN];
  wire       busy     = (busy_cnt_q != 16'h0000);
  wire       cmd_wr   = wr_go && (waddr_q == `SACG_OFF_CMD);
  wire       dbg_blk  = cmd_wr && wr_val[`SACG_CMD_DBG] && !ctrl_q[`SACG_CTRL_RUN];
  wire       cmd_ok   = cmd_wr && !dbg_blk;
  wire       mv_req   = cmd_ok && wr_val[`SACG_CMD_MOVE];
  wire       mv_dir   = wr_val[`SACG_CMD_DIR];
  wire       fref_req = cmd_ok && wr_val[`SACG_CMD_FREF];
  wire       awr_req  = cmd_ok && wr_val[`SACG_CMD_AWR];
  wire       ard_req  = cmd_ok && wr_val[`SACG_CMD_ARD];
  wire       sav_req  = cmd_ok && wr_val[`SACG_CMD_ASAVE];
  wire       cold_req = cmd_ok && wr_val[`SACG_CMD_COLD];
  wire       ack_rise = ctrl_q[`SACG_CTRL_ACK] && !ack_prev_q;
  wire       en_fall  = !enable && en_prev_q;
  wire       soft_hit = axis_run_q && ref_q && soft_f;
  wire       eor_hit  = axis_run_q && (axis_dir_q ? eor_hi_f : eor_lo_f);
  wire       stop_now = axis_run_q && (soft_hit || eor_hit || !enable ||
                        (cmd_ok && wr_val[`SACG_CMD_STOP]));
  wire       adj_end  = (busy_cnt_q == 16'h0001);
  reg  [7:0] mv_code;
  reg  [7:0] refuse_d;
  reg  [3:0] ev_d;
  reg  [3:0] irq_sts_d;

  // Move acceptance, first failing check names the refusal
  always @* begin
    if (!enable)
      mv_code = `SACG_REF_DISABLED;
    else if (mode == `SACG_MODE_IDLE)
      mv_code = `SACG_REF_NOMODE;
    else if (mode == `SACG_MODE_DIRECT && lock_q)
      mv_code = `SACG_REF_LOCKED;
    else if (fault_q || axis_run_q)
      mv_code = `SACG_REF_FAULT;
    else if ((mv_dir && eor_hi_f) || (!mv_dir && eor_lo_f))
      mv_code = `SACG_REF_EOR_DIR;
    else if (mode != `SACG_MODE_MANUAL && !ref_q)
      mv_code = `SACG_REF_NOTREF;
    else
      mv_code = `SACG_REF_NONE;
  end

  always @* begin
    refuse_d = `SACG_REF_NONE;
    if (dbg_blk)
      refuse_d = `SACG_REF_STOPPED;
    else if (mv_req && mv_code != `SACG_REF_NONE)
      refuse_d = mv_code;
    else if ((awr_req || ard_req || sav_req) && busy)
      refuse_d = `SACG_REF_ADJ_BUSY;
    else if (fref_req && (mode != `SACG_MODE_MANUAL || fault_q || axis_run_q || soft_f))
      refuse_d = `SACG_REF_FREF;
    ev_d = 4'h0;
    ev_d[`SACG_IRQ_REFUSE] = (refuse_d != `SACG_REF_NONE);
    ev_d[`SACG_IRQ_FAULT]  = soft_hit;
    ev_d[`SACG_IRQ_DONE]   = stop_now;
    ev_d[`SACG_IRQ_ADJ]    = adj_end;
    // New events win over a write-one-to-clear in the same cycle
    irq_sts_d = irq_sts_q | ev_d;
    if (wr_go && waddr_q == `SACG_OFF_IRQ_STS)
      irq_sts_d = (irq_sts_q & ~wr_val[3:0]) | ev_d;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= `SACG_CTRL_RESET;
      adj_new_q   <= 32'h0000_0000;
      adj_work_q  <= 32'h0000_0000;
      adj_pend_q  <= 32'h0000_0000;
      adj_read_q  <= 32'h0000_0000;
      adj_saved_q <= 32'h0000_0000;
      busy_cnt_q  <= 16'h0000;
      pend_wr_q   <= 1'b0;
      ref_q       <= 1'b0;
      fault_q     <= 1'b0;
      lock_q      <= 1'b0;
      ev_src_q    <= 1'b0;
      en_prev_q   <= 1'b0;
      ack_prev_q  <= 1'b0;
      exchange_report_word_q  <= 16'h0000;
      channel_fault_word_q    <= 16'h0000;
      refuse_q    <= 8'h00;
      irq_sts_q   <= 4'h0;
      irq_mask_q  <= 4'h0;
      axis_run_q  <= 1'b0;
      axis_dir_q  <= 1'b0;
      event_out_q <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      en_prev_q  <= enable;
      ack_prev_q <= ctrl_q[`SACG_CTRL_ACK];
      irq_sts_q  <= irq_sts_d;
      irq_q      <= |(irq_sts_d & irq_mask_q);
      if (refuse_d != `SACG_REF_NONE)
        refuse_q <= refuse_d;
      if (wr_go && waddr_q == `SACG_OFF_CTRL)
        ctrl_q <= wr_val[6:0];
      if (wr_go && waddr_q == `SACG_OFF_ADJ_NEW)
        adj_new_q <= (adj_new_q & ~be_mask(wstrb_q)) | wr_val;
      if (wr_go && waddr_q == `SACG_OFF_IRQ_MASK)
        irq_mask_q <= wr_val[3:0];

      // Adjustment exchanges
      if (busy) begin
        busy_cnt_q <= busy_cnt_q - 16'h0001;
        if (adj_end) begin
          if (pend_wr_q)
            adj_work_q <= adj_pend_q;
          else
            adj_read_q <= adj_work_q;
        end
      end else if (awr_req) begin
        adj_pend_q <= adj_new_q;
        pend_wr_q  <= 1'b1;
        busy_cnt_q <= ADJ_WR_CYCLES;
      end else if (ard_req) begin
        pend_wr_q  <= 1'b0;
        busy_cnt_q <= ADJ_RD_CYCLES;
      end else if (sav_req) begin
        adj_saved_q <= adj_work_q;
      end
      if (cold_req) begin
        adj_work_q <= adj_saved_q;
        busy_cnt_q <= 16'h0000;
        ref_q      <= 1'b0;
      end

      // Status snapshot on request only
      if (cmd_ok && wr_val[`SACG_CMD_STSRD]) begin
        exchange_report_word_q <= {refuse_q, 6'h00, pend_wr_q, busy};
        channel_fault_word_q   <= {11'h000, eor_lo_f, eor_hi_f, soft_f, lock_q, fault_q};
      end

      // Motion; reference survives mode changes so monitoring stays on
      event_out_q <= 1'b0;
      if (mv_req && mv_code == `SACG_REF_NONE) begin
        axis_run_q <= 1'b1;
        axis_dir_q <= mv_dir;
        ev_src_q   <= wr_val[`SACG_CMD_EVSRC];
      end else if (stop_now) begin
        axis_run_q  <= 1'b0;
        event_out_q <= ev_src_q && ctrl_q[`SACG_CTRL_EVT_AUTH] &&
                       ctrl_q[`SACG_CTRL_EVT_UNM];
      end
      if (soft_hit) begin
        fault_q <= 1'b1;
        if (mode == `SACG_MODE_DIRECT)
          lock_q <= 1'b1;
      end
      if (en_fall)
        ref_q <= 1'b0;
      if (ack_rise && !axis_run_q && !soft_hit) begin
        fault_q <= 1'b0;
        if (!ref_q)
          lock_q <= 1'b0;
      end
      if (fref_req && refuse_d == `SACG_REF_NONE) begin
        ref_q  <= 1'b1;
        lock_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Read multiplexer
  // ==========================================================================
  always @* begin
    case ({s_axi_araddr[7:2], 2'b00})
      `SACG_OFF_CTRL:      rd_d = {25'h000_0000, ctrl_q};
      `SACG_OFF_ADJ_NEW:   rd_d = adj_new_q;
      `SACG_OFF_ADJ_READ:  rd_d = adj_read_q;
      `SACG_OFF_ADJ_SAVED: rd_d = adj_saved_q;
      `SACG_OFF_STATUS:    rd_d = {22'h00_0000, pins_q, axis_dir_q, axis_run_q,
                                   lock_q, fault_q, ref_q, pend_wr_q, busy};
      `SACG_OFF_EXCHANGE_REPORT_WORD:  rd_d = {16'h0000, exchange_report_word_q};
      `SACG_OFF_CHANNEL_FAULT_WORD:    rd_d = {16'h0000, channel_fault_word_q};
      `SACG_OFF_REFUSE:    rd_d = {24'h00_0000, refuse_q};
      `SACG_OFF_IRQ_STS:   rd_d = {28'h000_0000, irq_sts_q};
      `SACG_OFF_IRQ_MASK:  rd_d = {28'h000_0000, irq_mask_q};
      default:             rd_d = 32'h0000_0000;
    endcase
  end

endmodule

`default_nettype wire

// [tb/sacg_top_asserts.sv]
// Checker for the stepper axis command guard: bus timing, stops and events.
// Assumes it is bound to sacg_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module sacg_top_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        eor_high_pin,
  input wire logic        axis_run_q,
  input wire logic        axis_dir_q,
  input wire logic        event_out_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // Sequences
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Pin sync takes four edges, so seven edges running into the limit is too late
  sequence up_past_limit;
    (axis_run_q && axis_dir_q && eor_high_pin) [*7];
  endsequence
  // ==========
  // Properties
  chk_wr_resp_time: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two edges after handshake");
  chk_wr_unmapped: assert property (wr_taken ##0 ({s_axi_awaddr[7:2], 2'b00} > 8'h28) |=> ##1 s_axi_bresp == 2'b11)
    else $error("unmapped write not answered with decode error");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one edge after address");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  chk_eor_stop: assert property (up_past_limit |=> !axis_run_q)
    else $error("axis kept moving past upper end of run");
  chk_dir_steady: assert property (axis_run_q && $past(axis_run_q) |-> $stable(axis_dir_q))
    else $error("direction changed during a move");
  chk_event_pulse: assert property (event_out_q |=> !event_out_q)
    else $error("event longer than one cycle");
  chk_event_stop: assert property (event_out_q |-> !axis_run_q && ($past(axis_run_q) || $past(axis_run_q, 2)))
    else $error("event without a motion stop");
  chk_start_by_cmd: assert property ($rose(axis_run_q) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("axis started without a command write");
endmodule
`default_nettype wire

// [tb/sacg_motion_model.sv]
// Moving part model: position follows the axis outputs and drives the limit pins.
// Assumes one step per clock while the axis runs; the bench may place it anywhere.
`timescale 1ns/1ps
`default_nettype none
module sacg_motion_model #(
  parameter int SOFT_HI = 60,
  parameter int SOFT_LO = -60,
  parameter int EOR_HI  = 100,
  parameter int EOR_LO  = -100
) (
  input  wire logic               aclk,
  input  wire logic               run,
  input  wire logic               dir,
  input  wire logic               place_en,
  input  wire logic signed [15:0] place_pos,
  output logic                    soft_over_pin,
  output logic                    eor_high_pin,
  output logic                    eor_low_pin
);
  logic signed [15:0] pos_q = '0;
  always @(posedge aclk) begin
    if (place_en)
      pos_q <= place_pos;
    else if (run)
      pos_q <= dir ? pos_q + 16'sh0001 : pos_q - 16'sh0001;
  end
  assign soft_over_pin = (pos_q > SOFT_HI) || (pos_q < SOFT_LO);
  assign eor_high_pin  = pos_q > EOR_HI;
  assign eor_low_pin   = pos_q < EOR_LO;
endmodule
`default_nettype wire

// [tb/sacg_top_tb_top.sv]
// Self-checking bench for the stepper axis command guard over AXI4-Lite.
// Assumes the moving part model and the checker are compiled before it.
`timescale 1ns/1ps
`include "sacg_defines.vh"
`default_nettype none
module sacg_top_tb_top;
  logic               aclk = 1'b0;
  logic               aresetn = 1'b0;
  logic [7:0]         s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]        s_axi_wdata = '0;
  logic [3:0]         s_axi_wstrb = 4'hf;
  logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic               s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pl_en = 1'b0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp, rs;
  logic [31:0]        s_axi_rdata, rv, v1, v2, v3;
  logic               soft_over_pin, eor_high_pin, eor_low_pin;
  logic               axis_run_q, axis_dir_q, event_out_q, irq_q;
  logic signed [15:0] pl_pos = '0;
  int                 n_mismatch = 0, tests_run = 0, n_evt = 0;

  initial forever #50 aclk = ~aclk;

  sacg_top #(.ADJ_WR_CYCLES(16'h0028), .ADJ_RD_CYCLES(16'h0005)) sacg_top_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .soft_over_pin, .eor_high_pin, .eor_low_pin, .axis_run_q, .axis_dir_q,
    .event_out_q, .irq_q);

  sacg_motion_model sacg_motion_model_i (.aclk, .run(axis_run_q), .dir(axis_dir_q),
    .place_en(pl_en), .place_pos(pl_pos), .soft_over_pin, .eor_high_pin, .eor_low_pin);

  always @(posedge aclk) if (event_out_q === 1'b1) n_evt <= n_evt + 1;

  // ==========
  // Expectations
  function automatic logic [31:0] bit_at(input int n);
    return 32'h0000_0001 << n;
  endfunction
  function automatic logic [31:0] cv(input logic en, ack, input logic [1:0] md, input logic ev);
    return {25'h000_0000, ev, ev, 1'b1, md, ack, en};
  endfunction
  function automatic logic [31:0] rpt(input logic [7:0] code);
    return {16'h0000, code, 8'h00};
  endfunction

  // ==========
  // Bus and compare tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, rv);
    chk(nm, e, rv);
  endtask
  task automatic cmd(input logic [31:0] d);
    wr(`SACG_OFF_CMD, d);
  endtask
  task automatic ctl(input logic [31:0] d);
    wr(`SACG_OFF_CTRL, d);
  endtask
  // Polls the busy flag so no exchange is launched over a running one
  task automatic idle_adj;
    do rd(`SACG_OFF_STATUS, rv); while (rv[0] !== 1'b0);
  endtask
  task automatic wait_stop;
    while (axis_run_q !== 1'b0) @(posedge aclk);
  endtask
  task automatic place(input logic signed [15:0] p);
    @(posedge aclk);
    pl_pos <= p;
    pl_en <= 1'b1;
    @(posedge aclk);
    pl_en <= 1'b0;
    // Lets the new pin levels through the synchroniser
    repeat (4) @(posedge aclk);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    wrap_up();
  end

  // ==========
  // Main sequence
  initial begin
    void'($urandom(92));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("ctrl", `SACG_OFF_CTRL, '0);
    rdc("irq_sts", `SACG_OFF_IRQ_STS, '0);
    rdc("status", `SACG_OFF_STATUS, '0);
    rd(8'h2C, rv);
    chk("rresp", 2'b11, rs);
    chk("rdata", '0, rv);
    wr(8'h30, 32'h0000_0001);
    chk("bresp", 2'b11, rs);
    wr(`SACG_OFF_IRQ_MASK, 32'h0000_0001);
    cmd(bit_at(`SACG_CMD_DBG) | bit_at(`SACG_CMD_MOVE));
    rdc("refuse", `SACG_OFF_REFUSE, `SACG_REF_STOPPED);
    chk("run", 1'b0, axis_run_q);
    chk("irq", 1'b1, irq_q);
    rdc("exch", `SACG_OFF_EXCHANGE_REPORT_WORD, '0);
    cmd(bit_at(`SACG_CMD_STSRD));
    rdc("exch", `SACG_OFF_EXCHANGE_REPORT_WORD, rpt(`SACG_REF_STOPPED));
    cmd(bit_at(`SACG_CMD_MOVE));
    rdc("refuse", `SACG_OFF_REFUSE, `SACG_REF_DISABLED);
    wr(`SACG_OFF_IRQ_STS, 32'h0000_0001);
    wr(`SACG_OFF_IRQ_MASK, '0);
    chk("irq", 1'b0, irq_q);
    v1 = $urandom;
    v2 = $urandom;
    v3 = $urandom;
    wr(`SACG_OFF_ADJ_NEW, v1);
    cmd(bit_at(`SACG_CMD_AWR));
    wr(`SACG_OFF_ADJ_NEW, v2);
    cmd(bit_at(`SACG_CMD_AWR));
    rdc("refuse", `SACG_OFF_REFUSE, `SACG_REF_ADJ_BUSY);
    chk("irq", 1'b0, irq_q);
    idle_adj();
    cmd(bit_at(`SACG_CMD_ARD));
    idle_adj();
    rdc("adj", `SACG_OFF_ADJ_READ, v1);
    cmd(bit_at(`SACG_CMD_ASAVE));
    idle_adj();
    rdc("saved", `SACG_OFF_ADJ_SAVED, v1);
    wr(`SACG_OFF_ADJ_NEW, v3);
    cmd(bit_at(`SACG_CMD_AWR));
    idle_adj();
    cmd(bit_at(`SACG_CMD_ARD));
    idle_adj();
    rdc("adj", `SACG_OFF_ADJ_READ, v3);
    cmd(bit_at(`SACG_CMD_COLD));
    cmd(bit_at(`SACG_CMD_ARD));
    idle_adj();
    rdc("adj", `SACG_OFF_ADJ_READ, v1);
    ctl(cv(1'b1, 1'b0, `SACG_MODE_MANUAL, 1'b1));
    cmd(bit_at(`SACG_CMD_FREF));
    ctl(cv(1'b1, 1'b0, `SACG_MODE_DIRECT, 1'b1));
    rd(`SACG_OFF_STATUS, rv);
    chk("ref", 1'b1, rv[2]);
    cmd(bit_at(`SACG_CMD_MOVE) | bit_at(`SACG_CMD_DIR) | bit_at(`SACG_CMD_EVSRC));
    chk("run", 1'b1, axis_run_q);
    wait_stop();
    rd(`SACG_OFF_STATUS, rv);
    chk("fault", 1'b1, rv[3]);
    chk("lock", 1'b1, rv[4]);
    rdc("flt", `SACG_OFF_CHANNEL_FAULT_WORD, '0);
    cmd(bit_at(`SACG_CMD_STSRD));
    rdc("flt", `SACG_OFF_CHANNEL_FAULT_WORD, 32'h0000_0007);
    rd(`SACG_OFF_IRQ_STS, rv);
    chk("soft_irq", 1'b1, rv[1]);
    cmd(bit_at(`SACG_CMD_MOVE));
    rdc("refuse", `SACG_OFF_REFUSE, `SACG_REF_LOCKED);
    cmd(bit_at(`SACG_CMD_FREF));
    rdc("refuse", `SACG_OFF_REFUSE, `SACG_REF_FREF);
    chk("run", 1'b0, axis_run_q);
    ctl(cv(1'b0, 1'b0, `SACG_MODE_DIRECT, 1'b1));
    ctl(cv(1'b1, 1'b0, `SACG_MODE_DIRECT, 1'b1));
    ctl(cv(1'b1, 1'b1, `SACG_MODE_DIRECT, 1'b1));
    rd(`SACG_OFF_STATUS, rv);
    chk("lock", 1'b0, rv[4]);
    chk("ref", 1'b0, rv[2]);
    cmd(bit_at(`SACG_CMD_MOVE));
    rdc("refuse", `SACG_OFF_REFUSE, `SACG_REF_NOTREF);
    place(16'sh005A);
    ctl(cv(1'b1, 1'b0, `SACG_MODE_MANUAL, 1'b0));
    cmd(bit_at(`SACG_CMD_MOVE) | bit_at(`SACG_CMD_DIR) | bit_at(`SACG_CMD_EVSRC));
    wait_stop();
    rd(`SACG_OFF_STATUS, rv);
    chk("eor_hi", 1'b1, rv[8]);
    cmd(bit_at(`SACG_CMD_MOVE) | bit_at(`SACG_CMD_DIR));
    rdc("refuse", `SACG_OFF_REFUSE, `SACG_REF_EOR_DIR);
    cmd(bit_at(`SACG_CMD_MOVE));
    chk("run", 1'b1, axis_run_q);
    chk("dir", 1'b0, axis_dir_q);
    cmd(bit_at(`SACG_CMD_STOP));
    wait_stop();
    place('0);
    cmd(bit_at(`SACG_CMD_FREF));
    ctl(cv(1'b1, 1'b0, `SACG_MODE_DIRECT, 1'b0));
    cmd(bit_at(`SACG_CMD_MOVE) | bit_at(`SACG_CMD_DIR) | bit_at(`SACG_CMD_EVSRC));
    wait_stop();
    place('0);
    ctl(cv(1'b1, 1'b0, `SACG_MODE_MANUAL, 1'b1));
    ctl(cv(1'b1, 1'b1, `SACG_MODE_MANUAL, 1'b1));
    cmd(bit_at(`SACG_CMD_FREF));
    ctl(cv(1'b1, 1'b0, `SACG_MODE_DIRECT, 1'b1));
    cmd(bit_at(`SACG_CMD_MOVE));
    chk("run", 1'b1, axis_run_q);
    cmd(bit_at(`SACG_CMD_STOP));
    wait_stop();
    repeat (3) @(posedge aclk);
    chk("events", 1, n_evt);
    wr(`SACG_OFF_IRQ_MASK, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    chk("irq", 1'b1, irq_q);
    wrap_up();
  end
endmodule

bind sacg_top sacg_top_asserts sacg_top_asserts_i (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .eor_high_pin,
  .axis_run_q, .axis_dir_q, .event_out_q);
`default_nettype wire
